// ### src/deflection_params.svh
// Offsets, field positions and timing counts for the deflection timing core.
`ifndef DEFLECTION_PARAMS_SVH
`define DEFLECTION_PARAMS_SVH
`define CLAMP_WIDTH 21
`define CLAMP_BASE 35
`define CLAMP_STEP 2
`define HBLANK_BASE 41
`define LINE_NOMINAL 432
`define VBLANK_DELAY 2
`define DEINTERLACE_DISABLE_SAMPLE_EARLY 42
`define DEINTERLACE_DISABLE_SAMPLE_LATE 258
`define SOFT_STEPS 2000
`define DUTY_START_PERMILLE 50
`define DUTY_RUN_PERMILLE 520
`define LINES_MIN 200
`define LINES_MAX 910
`define SLOPE_PER_LINE 72
`define GUARD_SMALL_X12 16
`define GUARD_LARGE_X12 48
`define AMP_FULL_PCT 100
`define AMP_COMP_PCT 75
`define AMP_LOW_PCT 20
`define UNBLANK_LINES 1
`endif

// ### src/deflection_pkg.sv
// Types shared by the deflection timing core.
package deflection_pkg;
    typedef enum logic [1:0] {V_SCAN, V_WAIT, V_STOP} vstate_t;
    typedef struct packed {
        logic slope_mode_select;
        logic wait_enable;
        logic vsync_edge_polarity;
        logic line_run_enable;
        logic deinterlace_disable;
        logic guardband_select;
        logic vertical_current_reduction;
        logic compression_enable;
        logic deinterlace_phase_select;
        logic clamp_suppress;
    } ctrl_t;
    typedef struct packed {
        logic [5:0] hphase;
        logic [5:0] offcentre;
        logic [2:0] clamp_shift;
        logic [5:0] start_scan;
        logic [15:0] slope;
        logic [7:0] wait_lines;
    } settings_t;
endpackage

// ### src/deflection_sync_timing_core.sv
// Line and field timing core of the deflection controller.
`include "deflection_params.svh"
module deflection_sync_timing_core #(
    parameter int SOFT_STEPS = `SOFT_STEPS,
    parameter int LINE_W = 10,
    parameter int LINE_CNT_W = 11
) (
    // Clock, reset and freeze.
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Clock prescaler control.
    input wire logic clock_prescaler_bypass,
    // Configuration.
    input wire deflection_pkg::ctrl_t ctrl,
    input wire deflection_pkg::settings_t settings,
    // Sync and flyback inputs.
    input wire logic hsync_in,
    input wire logic vsync_in,
    input wire logic flyback_in,
    input wire logic guard_current_ok,
    // Outputs.
    output logic line_drive_output,
    output logic offcentre_pwm_output,
    output logic sandcastle_blank,
    output logic sandcastle_clamp,
    output logic sandcastle_sense_en,
    output logic [6:0] vertical_amp_pct,
    output deflection_pkg::vstate_t vstate,
    output logic soft_start_active
);
    logic half_ff;
    logic tick;
    logic hs_d_ff, vs_d_ff, fb_d_ff;
    logic h_edge;
    logic [LINE_W-1:0] pos_ff;
    logic [LINE_W-1:0] line_len_ff;
    logic [LINE_W-1:0] fb_centre;
    logic [LINE_W-1:0] hb_start;
    logic [LINE_W-1:0] clamp_start;
    logic [LINE_W-1:0] sample_pos;
    logic [LINE_W-1:0] on_len;
    logic [LINE_W+9:0] on_prod;
    logic [11:0] soft_ff;
    logic [9:0] duty_pm;
    logic drive_ff, pwm_ff, hblank_ff, clamp_ff;
    logic vs_smp_ff;
    logic v_edge;
    logic [1:0] vb_dly_ff;
    logic vblank_ff;
    logic [6:0] vb_lines_ff;
    logic guard_seen_ff;
    logic [LINE_CNT_W-1:0] field_lines_ff;
    logic [LINE_CNT_W-1:0] ref_lines_ff;
    logic [7:0] wait_cnt_ff;
    deflection_pkg::vstate_t vst_ff;
    logic [6:0] amp_ff;

    // Prescaler as a clock enable keeps the design on a single clock tree.
    always_ff @(posedge mclk) begin
        if (!reset_n) half_ff <= 1'b0;
        else if (clk_en) half_ff <= ~half_ff;
    end
    assign tick = clk_en & (clock_prescaler_bypass | half_ff);

    // Edge detectors on synchronous inputs; pulse width limits are assumed.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            hs_d_ff <= 1'b0;
            vs_d_ff <= 1'b0;
            fb_d_ff <= 1'b0;
        end else if (tick) begin
            hs_d_ff <= hsync_in;
            vs_d_ff <= vsync_in;
            fb_d_ff <= flyback_in;
        end
    end
    assign h_edge = hsync_in & ~hs_d_ff;

    // Line position counter, restarted on each sync leading edge.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pos_ff <= '0;
            line_len_ff <= LINE_W'(`LINE_NOMINAL);
        end else if (tick) begin
            if (h_edge) begin
                pos_ff <= '0;
                line_len_ff <= pos_ff + LINE_W'(1);
            end else if (pos_ff != '1) begin
                pos_ff <= pos_ff + LINE_W'(1);
            end
        end
    end

    assign fb_centre = LINE_W'(`HBLANK_BASE) + LINE_W'(settings.hphase);
    // Blanking lead of 41-(432-K) with K the measured line length.
    assign hb_start = fb_centre - LINE_W'(`HBLANK_BASE)
                      + LINE_W'(`LINE_NOMINAL) - line_len_ff;
    assign clamp_start = LINE_W'(`CLAMP_BASE)
                         + LINE_W'(settings.clamp_shift) * LINE_W'(`CLAMP_STEP);
    assign sample_pos = ctrl.deinterlace_phase_select ? LINE_W'(`DEINTERLACE_DISABLE_SAMPLE_LATE)
                        : LINE_W'(`DEINTERLACE_DISABLE_SAMPLE_EARLY);

    // Soft start counts lines up to the run duty.
    always_ff @(posedge mclk) begin
        if (!reset_n) soft_ff <= '0;
        else if (tick) begin
            if (!ctrl.line_run_enable) soft_ff <= '0;
            else if (h_edge && soft_ff < 12'(SOFT_STEPS)) soft_ff <= soft_ff + 12'h001;
        end
    end
    assign soft_start_active = ctrl.line_run_enable && soft_ff < 12'(SOFT_STEPS);
    assign duty_pm = soft_start_active
        ? 10'(`DUTY_START_PERMILLE + ((`DUTY_RUN_PERMILLE - `DUTY_START_PERMILLE)
              * int'(soft_ff)) / SOFT_STEPS)
        : 10'(`DUTY_RUN_PERMILLE);
    assign on_prod = line_len_ff * duty_pm;
    assign on_len = LINE_W'(on_prod / 1000);

    always_ff @(posedge mclk) begin
        if (!reset_n) drive_ff <= 1'b0;
        else if (tick) drive_ff <= ctrl.line_run_enable && (pos_ff < on_len);
    end
    assign line_drive_output = drive_ff;

    // PWM period is the line, so it stays phase-locked.
    always_ff @(posedge mclk) begin
        if (!reset_n) pwm_ff <= 1'b0;
        else if (tick) pwm_ff <= (pos_ff[LINE_W-1:3] < (LINE_W-3)'(settings.offcentre));
    end
    assign offcentre_pwm_output = pwm_ff;

    always_ff @(posedge mclk) begin
        if (!reset_n) hblank_ff <= 1'b0;
        else if (tick) begin
            if (pos_ff == hb_start) hblank_ff <= 1'b1;
            else if (fb_d_ff && !flyback_in) hblank_ff <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) clamp_ff <= 1'b0;
        else if (tick) begin
            clamp_ff <= (pos_ff >= clamp_start)
                        && (pos_ff < clamp_start + LINE_W'(`CLAMP_WIDTH))
                        && !(ctrl.clamp_suppress && vst_ff != deflection_pkg::V_SCAN);
        end
    end

    // Vertical sync sampling and edge.
    always_ff @(posedge mclk) begin
        if (!reset_n) vs_smp_ff <= 1'b0;
        else if (tick) begin
            if (ctrl.deinterlace_disable) vs_smp_ff <= vsync_in;
            else if (pos_ff == sample_pos) vs_smp_ff <= vsync_in;
        end
    end
    logic vs_prev_ff;
    always_ff @(posedge mclk) begin
        if (!reset_n) vs_prev_ff <= 1'b0;
        else if (tick) vs_prev_ff <= vs_smp_ff;
    end
    assign v_edge = ctrl.vsync_edge_polarity ? (vs_prev_ff & ~vs_smp_ff)
                    : (~vs_prev_ff & vs_smp_ff);

    // Vertical blanking with guard check.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            vb_dly_ff <= '0;
            vblank_ff <= 1'b0;
            vb_lines_ff <= '0;
            guard_seen_ff <= 1'b0;
        end else if (tick) begin
            vb_dly_ff <= {vb_dly_ff[0], v_edge};
            if (vb_dly_ff[1]) begin
                vblank_ff <= 1'b1;
                vb_lines_ff <= '0;
                guard_seen_ff <= 1'b0;
            end else if (vblank_ff) begin
                if (sandcastle_sense_en && guard_current_ok) guard_seen_ff <= 1'b1;
                if (h_edge) begin
                    if (vb_lines_ff <= 7'(settings.start_scan)) vb_lines_ff <= vb_lines_ff + 7'h01;
                    else if (guard_seen_ff) vblank_ff <= 1'b0;
                end
            end
        end
    end
    // Unblank window is the line after the first line edge of the blanking interval.
    assign sandcastle_sense_en = vblank_ff && vb_lines_ff == 7'(`UNBLANK_LINES);
    assign sandcastle_blank = (hblank_ff || vblank_ff) && !sandcastle_sense_en;
    assign sandcastle_clamp = clamp_ff && !sandcastle_blank;

    // Field line count, reference and vertical state.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            field_lines_ff <= '0;
            ref_lines_ff <= LINE_CNT_W'(`LINES_MAX);
            vst_ff <= deflection_pkg::V_SCAN;
            wait_cnt_ff <= '0;
        end else if (tick) begin
            logic reset_v;
            logic [LINE_CNT_W-1:0] d;
            reset_v = (v_edge && field_lines_ff >= LINE_CNT_W'(`LINES_MIN))
                      || (h_edge && field_lines_ff >= LINE_CNT_W'(`LINES_MAX));
            d = (field_lines_ff > ref_lines_ff) ? field_lines_ff - ref_lines_ff
                : ref_lines_ff - field_lines_ff;
            if (reset_v) begin
                field_lines_ff <= '0;
                vst_ff <= deflection_pkg::V_SCAN;
                // Compare twelve times the difference against the guardband.
                if (({4'h0, d} * 15'(12)) >= (ctrl.guardband_select
                        ? 15'(`GUARD_LARGE_X12) : 15'(`GUARD_SMALL_X12)))
                    ref_lines_ff <= field_lines_ff;
            end else if (h_edge) begin
                field_lines_ff <= field_lines_ff + LINE_CNT_W'(1);
                case (vst_ff)
                    deflection_pkg::V_SCAN: begin
                        if (ctrl.slope_mode_select
                            && {5'h00, field_lines_ff} * 16'(`SLOPE_PER_LINE) >= settings.slope) begin
                            if (ctrl.wait_enable) begin
                                vst_ff <= deflection_pkg::V_WAIT;
                                wait_cnt_ff <= settings.wait_lines;
                            end else vst_ff <= deflection_pkg::V_STOP;
                        end
                    end
                    deflection_pkg::V_WAIT: begin
                        if (wait_cnt_ff == 8'h00) vst_ff <= deflection_pkg::V_STOP;
                        else wait_cnt_ff <= wait_cnt_ff - 8'h01;
                    end
                    deflection_pkg::V_STOP: vst_ff <= deflection_pkg::V_STOP;
                    default: vst_ff <= deflection_pkg::V_SCAN;
                endcase
            end
        end
    end
    assign vstate = vst_ff;

    // Amplitude as a percentage for the analog stage.
    always_ff @(posedge mclk) begin
        if (!reset_n) amp_ff <= 7'(`AMP_LOW_PCT);
        else if (tick) begin
            if (!ctrl.line_run_enable
                || (ctrl.vertical_current_reduction && vst_ff != deflection_pkg::V_SCAN))
                amp_ff <= 7'(`AMP_LOW_PCT);
            else if (ctrl.compression_enable) amp_ff <= 7'(`AMP_COMP_PCT);
            else amp_ff <= 7'(`AMP_FULL_PCT);
        end
    end
    assign vertical_amp_pct = amp_ff;

    a_drive_stops: assert property (@(posedge mclk) disable iff (!reset_n)
        (tick && !ctrl.line_run_enable) |=> !line_drive_output)
        else $error("line drive active while stopped");
    a_vblank_delay: assert property (@(posedge mclk) disable iff (!reset_n)
        (tick && vb_dly_ff[1]) |=> vblank_ff)
        else $error("vertical blanking not started");
    a_amp_low: assert property (@(posedge mclk) disable iff (!reset_n)
        (tick && !ctrl.line_run_enable) |=> vertical_amp_pct == 7'd20)
        else $error("vertical amplitude not reduced");
    a_amp_comp: assert property (@(posedge mclk) disable iff (!reset_n)
        (tick && ctrl.line_run_enable && ctrl.compression_enable && vst_ff == deflection_pkg::V_SCAN)
        |=> vertical_amp_pct == 7'd75)
        else $error("compression amplitude wrong");
    a_clamp_supp: assert property (@(posedge mclk) disable iff (!reset_n)
        (tick && ctrl.clamp_suppress && vst_ff != deflection_pkg::V_SCAN) |=> !clamp_ff)
        else $error("clamp not suppressed");
    a_clamp_pos: assert property (@(posedge mclk) disable iff (!reset_n)
        (tick && pos_ff < LINE_W'(`CLAMP_BASE)) |=> !clamp_ff)
        else $error("clamp too early");
    a_clamp_late: assert property (@(posedge mclk) disable iff (!reset_n)
        (tick && pos_ff >= clamp_start + LINE_W'(`CLAMP_WIDTH)) |=> !clamp_ff)
        else $error("clamp too long");
    a_hblank_set: assert property (@(posedge mclk) disable iff (!reset_n)
        (tick && pos_ff == hb_start) |=> hblank_ff)
        else $error("horizontal blanking not started");
    a_line_restart: assert property (@(posedge mclk) disable iff (!reset_n)
        (tick && h_edge) |=> pos_ff == '0)
        else $error("line counter not restarted");
    a_pwm_high: assert property (@(posedge mclk) disable iff (!reset_n)
        (tick && pos_ff[LINE_W-1:3] < (LINE_W-3)'(settings.offcentre)) |=> offcentre_pwm_output)
        else $error("offcentre pwm low inside duty");
    a_pwm_low: assert property (@(posedge mclk) disable iff (!reset_n)
        (tick && pos_ff[LINE_W-1:3] >= (LINE_W-3)'(settings.offcentre)) |=> !offcentre_pwm_output)
        else $error("offcentre pwm high outside duty");
    a_drive_on: assert property (@(posedge mclk) disable iff (!reset_n)
        (tick && ctrl.line_run_enable && pos_ff < on_len) |=> line_drive_output)
        else $error("line drive missing in conduct window");
    a_drive_off: assert property (@(posedge mclk) disable iff (!reset_n)
        (tick && pos_ff >= on_len) |=> !line_drive_output)
        else $error("line drive beyond conduct window");
    a_guard_latch: assert property (@(posedge mclk) disable iff (!reset_n)
        (tick && !vb_dly_ff[1] && vblank_ff && sandcastle_sense_en && guard_current_ok)
        |=> guard_seen_ff)
        else $error("guard current not latched");
    a_vblank_hold: assert property (@(posedge mclk) disable iff (!reset_n)
        (tick && vblank_ff && !h_edge) |=> vblank_ff)
        else $error("vertical blanking ended off a line edge");
    a_amp_full: assert property (@(posedge mclk) disable iff (!reset_n)
        (tick && ctrl.line_run_enable && !ctrl.compression_enable
         && !ctrl.vertical_current_reduction) |=> vertical_amp_pct == 7'(`AMP_FULL_PCT))
        else $error("full amplitude wrong");
    a_hblank_end: assert property (@(posedge mclk) disable iff (!reset_n)
        (tick && fb_d_ff && !flyback_in && pos_ff != hb_start) |=> !hblank_ff)
        else $error("horizontal blanking not ended");
    a_vblank_guard: assert property (@(posedge mclk) disable iff (!reset_n)
        ($fell(vblank_ff)) |-> $past(guard_seen_ff))
        else $error("blanking ended without guard");
    a_soft_zero: assert property (@(posedge mclk) disable iff (!reset_n)
        (tick && !ctrl.line_run_enable) |=> soft_ff == 12'h000)
        else $error("soft start not rearmed");
    c_soft_done: cover property (@(posedge mclk) disable iff (!reset_n) $fell(soft_start_active));
    c_vblank_end: cover property (@(posedge mclk) disable iff (!reset_n) $fell(vblank_ff));
    c_wait: cover property (@(posedge mclk) disable iff (!reset_n)
        vst_ff == deflection_pkg::V_WAIT);
    c_clamp: cover property (@(posedge mclk) disable iff (!reset_n) $rose(sandcastle_clamp));
    c_stop: cover property (@(posedge mclk) disable iff (!reset_n)
        vst_ff == deflection_pkg::V_STOP);
endmodule // deflection_sync_timing_core

// ### tb/sync_source_model.sv
// Video sync source and flyback stage model facing the timing core.
module sync_source_model (
    // Line geometry and requests from the bench, and the sense window from the core.
    input wire logic mclk,
    input wire logic [9:0] line_len,
    input wire logic vsync_req,
    input wire logic sense_en,
    // Lines into the core.
    output logic hsync_in = 1'b0,
    output logic vsync_in = 1'b0,
    output logic flyback_in = 1'b0,
    output logic guard_current_ok = 1'b0
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [9:0] pos_ff = 10'h000;
    always @(posedge mclk) begin
        pos_ff <= (pos_ff >= line_len - 10'h001) ? 10'h000 : pos_ff + 10'h001;
        // Eight clocks high keeps four internal periods even with the prescaler on.
        hsync_in <= #1 (pos_ff < 10'h008);
        flyback_in <= #1 (pos_ff >= 10'h01C) && (pos_ff < 10'h03C);
        vsync_in <= #1 vsync_req;
        // The output stage only fills the unblank pulse while the core senses.
        guard_current_ok <= #1 sense_en;
    end
endmodule // sync_source_model

// ### tb/deflection_sync_timing_core_tb.sv
// Self-checking bench for the deflection timing core.
module deflection_sync_timing_core_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic bypass = 1'b1;
    deflection_pkg::ctrl_t ctrl = '0;
    deflection_pkg::settings_t settings = '0;
    logic hsync_in, vsync_in, flyback_in, guard_current_ok;
    logic line_drive_output, offcentre_pwm_output, sandcastle_blank, sandcastle_clamp;
    logic sandcastle_sense_en, soft_start_active;
    logic [6:0] vertical_amp_pct;
    deflection_pkg::vstate_t vstate;
    logic [9:0] line_len = 10'h060;
    logic vsync_req = 1'b0;
    logic forbid = 1'b0;
    logic hs_d = 1'b0;
    logic cl_d = 1'b0;
    logic [31:0] seed = 32'h0000_0005;
    int err_count = 0;
    int comparisons = 0;
    int since = 0;
    int start_at = 0;
    int hi_cnt = 0;
    int low_cnt = 0;
    int pwm_cnt = 0;
    int pwm_q[$];
    int cw_q[$];
    int cs_q[$];
    int duty_q[$];
    always #2.5 mclk = ~mclk;
    deflection_sync_timing_core #(.SOFT_STEPS(4)) uut (
        .mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .clock_prescaler_bypass(bypass),
        .ctrl(ctrl), .settings(settings), .hsync_in(hsync_in), .vsync_in(vsync_in),
        .flyback_in(flyback_in), .guard_current_ok(guard_current_ok),
        .line_drive_output(line_drive_output), .offcentre_pwm_output(offcentre_pwm_output),
        .sandcastle_blank(sandcastle_blank), .sandcastle_clamp(sandcastle_clamp),
        .sandcastle_sense_en(sandcastle_sense_en), .vertical_amp_pct(vertical_amp_pct),
        .vstate(vstate), .soft_start_active(soft_start_active)
    );
    sync_source_model src (
        .mclk(mclk), .line_len(line_len), .vsync_req(vsync_req), .sense_en(sandcastle_sense_en),
        .hsync_in(hsync_in), .vsync_in(vsync_in), .flyback_in(flyback_in),
        .guard_current_ok(guard_current_ok)
    );
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s: got %0h expected %0h", $time, what, got, exp);
        end
    endtask
    task automatic check_near(input int got, input int lo, input int hi, input string what);
        comparisons++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("[FAIL] %0t %s: got %0d expected %0d to %0d", $time, what, got, lo, hi);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic conclude();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Watches clamp pulses and line drive duty, taking the oldest note at each result.
    always @(posedge mclk) begin
        int exp;
        int wid;
        since = (hsync_in && !hs_d) ? 0 : since + 1;
        if (hsync_in && !hs_d) begin
            if (pwm_q.size() != 0) begin
                exp = pwm_q.pop_front();
                check_near(pwm_cnt, exp - 1, exp + 1, "offcentre duty");
            end
            pwm_cnt = 0;
            if (duty_q.size() != 0) begin
                exp = duty_q.pop_front();
                check_near(hi_cnt, exp - 2, exp + 2, "line drive duty");
            end
            hi_cnt = 0;
        end
        if (line_drive_output === 1'b1) hi_cnt++;
        if (offcentre_pwm_output === 1'b1) pwm_cnt++;
        if (sandcastle_blank === 1'b0) low_cnt++;
        if (sandcastle_clamp && !cl_d) start_at = since;
        if (!sandcastle_clamp && cl_d) begin
            if (cw_q.size() != 0) begin
                exp = cs_q.pop_front();
                wid = cw_q.pop_front();
                check_near(since - start_at, wid, wid, "clamp width");
                if (exp >= 0) check_near(start_at, exp + 1, exp + 3, "clamp start");
            end else if (forbid) begin
                check_val(16'h0001, 16'h0000, "clamp while suppressed");
            end
        end
        hs_d = hsync_in;
        cl_d = sandcastle_clamp;
    end
    initial begin
        ctrl.deinterlace_disable = 1'b1;
        seed = xorshift(seed);
        settings.hphase = seed[5:0];
        seed = xorshift(seed);
        settings.offcentre = seed[5:0];
        seed = xorshift(seed);
        settings.start_scan = seed[5:0];
        repeat (20) @(posedge mclk);
        #1 reset_n = 1'b1;
        check_val({9'h000, vertical_amp_pct}, 16'h0014, "amplitude at reset");
        check_val({14'h0000, vstate}, {14'h0000, deflection_pkg::V_SCAN}, "state at reset");
        ctrl.line_run_enable = 1'b1;
        cycles(96);
        check_val({15'h0000, soft_start_active}, 16'h0001, "soft start running");
        cycles(6 * 96);
        check_val({15'h0000, soft_start_active}, 16'h0000, "soft start over");
        duty_q.push_back(96 * 520 / 1000);
        duty_q.push_back(96 * 520 / 1000);
        pwm_q.push_back((settings.offcentre * 8 > 96) ? 96 : settings.offcentre * 8);
        pwm_q.push_back((settings.offcentre * 8 > 96) ? 96 : settings.offcentre * 8);
        cycles(3 * 96);
        check_val({9'h000, vertical_amp_pct}, 16'h0064, "full amplitude");
        ctrl.compression_enable = 1'b1;
        cycles(2);
        check_val({9'h000, vertical_amp_pct}, 16'h004B, "compressed amplitude");
        ctrl.compression_enable = 1'b0;
        for (int s = 0; s < 8; s++) begin
            settings.clamp_shift = s[2:0];
            cycles(96);
            cw_q.push_back(21);
            cs_q.push_back(35 + 2 * s);
            cycles(96);
        end
        // The prescaler is only switched while the line drive is stopped.
        ctrl.line_run_enable = 1'b0;
        cycles(2);
        bypass = 1'b0;
        line_len = 10'h0C0;
        settings.clamp_shift = 3'h0;
        cycles(400);
        cw_q.push_back(42);
        cs_q.push_back(-1);
        cycles(2 * 192);
        bypass = 1'b1;
        line_len = 10'h060;
        cycles(2);
        ctrl.line_run_enable = 1'b1;
        ctrl.slope_mode_select = 1'b1;
        ctrl.vertical_current_reduction = 1'b1;
        ctrl.clamp_suppress = 1'b1;
        settings.slope = 16'h3840;
        for (int n = 0; n < 40000 && vstate !== deflection_pkg::V_STOP; n++) @(posedge mclk);
        #1;
        check_val({14'h0000, vstate}, {14'h0000, deflection_pkg::V_STOP}, "stop state");
        check_val({9'h000, vertical_amp_pct}, 16'h0014, "reduced amplitude");
        forbid = 1'b1;
        cycles(3 * 96);
        forbid = 1'b0;
        vsync_req = 1'b1;
        cycles(6);
        check_val({15'h0000, sandcastle_blank}, 16'h0001, "vertical blank start");
        cycles(40);
        check_val({15'h0000, sandcastle_blank}, 16'h0001, "vertical blank holds");
        cycles(2 * 96);
        vsync_req = 1'b0;
        cycles((settings.start_scan + 4) * 96);
        check_val({14'h0000, vstate}, {14'h0000, deflection_pkg::V_SCAN}, "field restart");
        low_cnt = 0;
        cycles(96);
        check_near(low_cnt, 1, 96, "blanking released after guard");
        conclude();
    end
    initial begin
        #400000;
        err_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        conclude();
    end
endmodule // deflection_sync_timing_core_tb
